// [hdl/iac_pkg.sv]
// constants and types shared by the interrupt acceptance logic
package iac_pkg;
  localparam int NUM_SRC = 8;
  localparam int SRC_W = 3;
  // source index 0 carries the highest maskable priority
  localparam logic [2:0] SRC_EXT_A = 3'h0;
  localparam logic [2:0] SRC_EXT_B = 3'h1;

  localparam logic [15:0] ADDR_REQ_FLAGS = 16'hffe0;
  localparam logic [15:0] ADDR_MASK_FLAGS = 16'hffe4;
  localparam logic [15:0] ADDR_EDGE_MODE = 16'hffec;

  localparam logic [7:0] REQ_FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_FLAGS_RESET = 8'hff;
  localparam logic [7:0] EDGE_MODE_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h02;

  localparam int EDGE_SEL_B_LO = 4;
  localparam int EDGE_SEL_B_HI = 5;
  localparam int EDGE_SEL_A_LO = 2;
  localparam int EDGE_SEL_A_HI = 3;
  localparam logic [7:0] EDGE_MODE_WMASK = 8'h3c;
  localparam int IE_BIT = 7;

  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BAD = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // instructions that touch request or mask flags defer the next two boundaries
  localparam logic [1:0] HOLD_BOUNDARIES = 2'h2;

  // request to service latency in cpu clocks, held by the core plus this sequence
  localparam int LAT_MIN_CLK = 9;
  localparam int LAT_MAX_CLK = 19;

  typedef enum logic [1:0] {
    IAC_IDLE = 2'b00,
    IAC_PUSH_PSW = 2'b01,
    IAC_PUSH_PC = 2'b10,
    IAC_VECTOR = 2'b11
  } iac_state_e;
endpackage

// [hdl/iac_edge_det.sv]
// valid edge detector for one external interrupt input
`timescale 1ns/1ps
module iac_edge_det (
  input wire logic clock,
  input wire logic nrst,
  input wire logic level,
  input wire logic [1:0] mode,
  output logic edge_hit
);
  logic prev_q, prev_d;
  logic valid_q, valid_d;

  always_comb begin
    prev_d = level;
    valid_d = 1'b1;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      valid_q <= valid_d;
    end
  end

  // compare this cycle with the last; the first cycle after reset has no history
  always_comb begin
    edge_hit = 1'b0;
    if (valid_q) begin
      case (mode)
        iac_pkg::EDGE_FALL: edge_hit = prev_q & ~level;
        iac_pkg::EDGE_RISE: edge_hit = ~prev_q & level;
        iac_pkg::EDGE_BOTH: edge_hit = prev_q ^ level;
        default: edge_hit = 1'b0;
      endcase
    end
  end

  property p_bad_code_silent;
    @(posedge clock) disable iff (!nrst)
    mode == iac_pkg::EDGE_BAD |-> !edge_hit;
  endproperty
  a_bad_code_silent: assert property (p_bad_code_silent) else $error("prohibited edge code detected");
endmodule

// [hdl/iac_accept.sv]
// interrupt acceptance: edge select, flags, arbitration, acknowledge sequence
`timescale 1ns/1ps
module iac_accept (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ext_irq_in_a,
  input wire logic ext_irq_in_b,
  input wire logic [7:0] periph_req,
  input wire logic nmi_req,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic psw_wr,
  input wire logic [7:0] psw_wdata,
  input wire logic irq_on_instr,
  input wire logic irq_off_instr,
  input wire logic return_from_irq_instr,
  input wire logic psw_pop,
  input wire logic [7:0] psw_stack_data,
  output logic [7:0] program_status_word,
  input wire logic instr_penult,
  input wire logic instr_last,
  output logic ack_busy,
  output logic push_psw,
  output logic push_pc,
  output logic vec_load,
  output logic vec_nmi,
  output logic [2:0] vec_src
);
  logic [7:0] req_q, req_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] edge_mode_q, edge_mode_d;
  logic [7:0] psw_q, psw_d;
  logic [7:0] rdata_q, rdata_d;
  logic nmi_flag_q, nmi_flag_d;
  logic nmi_active_q, nmi_active_d;
  logic snap_q, snap_d;
  logic [1:0] hold_q, hold_d;
  logic vec_nmi_q, vec_nmi_d;
  logic [2:0] vec_src_q, vec_src_d;
  iac_pkg::iac_state_e state_q, state_d;

  logic [1:0] ext_level;
  logic [1:0] ext_hit;
  logic [1:0] ext_mode [2];
  logic [7:0] set_vec;
  logic [7:0] elig;
  logic nmi_elig;
  logic any_elig;
  logic [2:0] pick;
  logic flag_access;
  logic start;
  logic ie;

  assign ie = psw_q[iac_pkg::IE_BIT];
  assign ext_level = {ext_irq_in_b, ext_irq_in_a};
  assign ext_mode[0] = edge_mode_q[iac_pkg::EDGE_SEL_A_HI:iac_pkg::EDGE_SEL_A_LO];
  assign ext_mode[1] = edge_mode_q[iac_pkg::EDGE_SEL_B_HI:iac_pkg::EDGE_SEL_B_LO];

  for (genvar g = 0; g < 2; g++) begin : g_ext
    iac_edge_det u_edge (
      .clock(clock),
      .nrst(nrst),
      .level(ext_level[g]),
      .mode(ext_mode[g]),
      .edge_hit(ext_hit[g])
    );
  end

  always_comb begin
    set_vec = periph_req;
    set_vec[iac_pkg::SRC_EXT_A] = periph_req[iac_pkg::SRC_EXT_A] | ext_hit[0];
    set_vec[iac_pkg::SRC_EXT_B] = periph_req[iac_pkg::SRC_EXT_B] | ext_hit[1];
  end

  // arbitration; a routine that leaves enable low blocks maskable nesting by itself, the non-maskable request is not gated by enable
  assign elig = req_q & ~mask_q & {8{ie}};
  assign nmi_elig = nmi_flag_q & ~nmi_active_q;
  assign any_elig = nmi_elig | (|elig);

  always_comb begin
    pick = 3'h0;
    for (int i = iac_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (elig[i]) begin
        pick = i[2:0];
      end
    end
  end

  assign flag_access = (reg_wr | reg_rd) &
    (reg_addr == iac_pkg::ADDR_REQ_FLAGS || reg_addr == iac_pkg::ADDR_MASK_FLAGS);
  // decision at the boundary uses the snapshot from the second-to-last clock
  assign start = (state_q == iac_pkg::IAC_IDLE) & instr_last & snap_q &
    (hold_q == 2'h0) & any_elig;

  always_comb begin
    state_d = state_q;
    case (state_q)
      iac_pkg::IAC_IDLE: begin
        if (start) begin
          state_d = iac_pkg::IAC_PUSH_PSW;
        end
      end
      iac_pkg::IAC_PUSH_PSW: state_d = iac_pkg::IAC_PUSH_PC;
      iac_pkg::IAC_PUSH_PC: state_d = iac_pkg::IAC_VECTOR;
      iac_pkg::IAC_VECTOR: state_d = iac_pkg::IAC_IDLE;
      default: state_d = iac_pkg::IAC_IDLE;
    endcase
  end

  always_comb begin
    snap_d = snap_q;
    if (instr_last) begin
      snap_d = 1'b0;
    end else if (instr_penult && state_q == iac_pkg::IAC_IDLE) begin
      snap_d = any_elig;
    end
    hold_d = hold_q;
    if (flag_access) begin
      hold_d = iac_pkg::HOLD_BOUNDARIES;
    end else if (instr_last && hold_q != 2'h0) begin
      hold_d = hold_q - 2'h1;
    end
    vec_nmi_d = vec_nmi_q;
    vec_src_d = vec_src_q;
    if (start) begin
      vec_nmi_d = nmi_elig;
      vec_src_d = pick;
    end
  end

  always_comb begin
    req_d = req_q;
    if (reg_wr && reg_addr == iac_pkg::ADDR_REQ_FLAGS) begin
      req_d = reg_wdata;
    end
    if (start && !nmi_elig) begin
      req_d[pick] = 1'b0;
    end
    req_d = req_d | set_vec; // a new event beats any clear
    mask_d = mask_q;
    if (reg_wr && reg_addr == iac_pkg::ADDR_MASK_FLAGS) begin
      mask_d = reg_wdata;
    end
    edge_mode_d = edge_mode_q;
    if (reg_wr && reg_addr == iac_pkg::ADDR_EDGE_MODE) begin
      // only the selector fields are kept; software is expected to write 0 elsewhere
      edge_mode_d = reg_wdata & iac_pkg::EDGE_MODE_WMASK;
    end
    nmi_flag_d = nmi_flag_q;
    if (start && nmi_elig) begin
      nmi_flag_d = 1'b0;
    end
    nmi_flag_d = nmi_flag_d | nmi_req;
    nmi_active_d = nmi_active_q;
    if (return_from_irq_instr) begin
      nmi_active_d = 1'b0;
    end
    if (start && nmi_elig) begin
      nmi_active_d = 1'b1;
    end
  end

  always_comb begin
    psw_d = psw_q;
    if (return_from_irq_instr || psw_pop) begin
      psw_d = psw_stack_data;
    end else if (psw_wr) begin
      psw_d = psw_wdata;
    end
    if (irq_on_instr) begin
      psw_d[iac_pkg::IE_BIT] = 1'b1;
    end
    if (irq_off_instr) begin
      psw_d[iac_pkg::IE_BIT] = 1'b0;
    end
    if (state_q == iac_pkg::IAC_PUSH_PSW) begin
      psw_d[iac_pkg::IE_BIT] = 1'b0;
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        iac_pkg::ADDR_REQ_FLAGS: rdata_d = req_q;
        iac_pkg::ADDR_MASK_FLAGS: rdata_d = mask_q;
        iac_pkg::ADDR_EDGE_MODE: rdata_d = edge_mode_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= iac_pkg::IAC_IDLE;
      req_q <= iac_pkg::REQ_FLAGS_RESET;
      mask_q <= iac_pkg::MASK_FLAGS_RESET;
      edge_mode_q <= iac_pkg::EDGE_MODE_RESET;
      psw_q <= iac_pkg::PSW_RESET;
      rdata_q <= 8'h00;
      nmi_flag_q <= 1'b0;
      nmi_active_q <= 1'b0;
      snap_q <= 1'b0;
      hold_q <= 2'h0;
      vec_nmi_q <= 1'b0;
      vec_src_q <= 3'h0;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      mask_q <= mask_d;
      edge_mode_q <= edge_mode_d;
      psw_q <= psw_d;
      rdata_q <= rdata_d;
      nmi_flag_q <= nmi_flag_d;
      nmi_active_q <= nmi_active_d;
      snap_q <= snap_d;
      hold_q <= hold_d;
      vec_nmi_q <= vec_nmi_d;
      vec_src_q <= vec_src_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign program_status_word = psw_q;
  assign ack_busy = state_q != iac_pkg::IAC_IDLE;
  assign push_psw = state_q == iac_pkg::IAC_PUSH_PSW;
  assign push_pc = state_q == iac_pkg::IAC_PUSH_PC;
  assign vec_load = state_q == iac_pkg::IAC_VECTOR;
  assign vec_nmi = vec_nmi_q;
  assign vec_src = vec_src_q;

  // eligible sources with an index below the winner, which rank above it, used to check the priority order
  logic [7:0] higher_than_pick;
  assign higher_than_pick = elig & ((8'h01 << pick) - 8'h01);

  property p_seq_order;
    @(posedge clock) disable iff (!nrst)
    start |=> push_psw ##1 push_pc ##1 vec_load ##1 !ack_busy;
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("acknowledge sequence out of order");

  property p_ie_cleared;
    @(posedge clock) disable iff (!nrst)
    push_psw && !irq_on_instr |=> !program_status_word[iac_pkg::IE_BIT];
  endproperty
  a_ie_cleared: assert property (p_ie_cleared) else $error("enable not cleared on acknowledge");

  property p_nmi_wins;
    @(posedge clock) disable iff (!nrst)
    start && nmi_elig |=> vec_nmi ##2 vec_load && vec_nmi;
  endproperty
  a_nmi_wins: assert property (p_nmi_wins) else $error("maskable beat non-maskable");

  property p_no_nmi_nest;
    @(posedge clock) disable iff (!nrst)
    nmi_active_q && !return_from_irq_instr |=> !(start && nmi_elig);
  endproperty
  a_no_nmi_nest: assert property (p_no_nmi_nest) else $error("nested non-maskable taken");

  property p_mask_gate;
    @(posedge clock) disable iff (!nrst)
    start && !nmi_elig |-> ie && req_q[pick] && !mask_q[pick];
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("ineligible maskable taken");

  property p_priority;
    @(posedge clock) disable iff (!nrst)
    start && !nmi_elig |-> higher_than_pick == 8'h00 ##1 vec_src == $past(pick);
  endproperty
  a_priority: assert property (p_priority) else $error("lower priority taken first");

  property p_flag_cleared;
    @(posedge clock) disable iff (!nrst)
    start && !nmi_elig && !set_vec[pick] |=> !req_q[vec_src];
  endproperty
  a_flag_cleared: assert property (p_flag_cleared) else $error("request flag kept on accept");

  property p_hold_blocks;
    @(posedge clock) disable iff (!nrst)
    flag_access |=> !start throughout (hold_q != 2'h0)[*2];
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) else $error("request taken during hold");

  property p_last_clock_defers;
    @(posedge clock) disable iff (!nrst)
    instr_last && $past(instr_penult) && !$past(any_elig) |-> !start;
  endproperty
  a_last_clock_defers: assert property (p_last_clock_defers) else $error("late flag taken early");

  property p_ie_on;
    @(posedge clock) disable iff (!nrst)
    irq_on_instr && !irq_off_instr && !push_psw |=> program_status_word[iac_pkg::IE_BIT];
  endproperty
  a_ie_on: assert property (p_ie_on) else $error("enable instruction ignored");

  c_nmi_ack: cover property (@(posedge clock) disable iff (!nrst) start && nmi_elig);
  c_mask_ack: cover property (@(posedge clock) disable iff (!nrst) start && !nmi_elig);
  c_hold: cover property (@(posedge clock) disable iff (!nrst)
    instr_last && snap_q && hold_q != 2'h0 && any_elig);
  c_pending_two: cover property (@(posedge clock) disable iff (!nrst) start && $countones(elig) > 1);
endmodule

// [sim/iac_core_model.sv]
// behavioural cpu core: instruction boundaries and status word stack
`timescale 1ns/1ps
module iac_core_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] instr_len,
  input wire logic ack_busy,
  input wire logic push_psw,
  input wire logic [7:0] program_status_word,
  output logic instr_penult,
  output logic instr_last,
  output logic [7:0] psw_stack_data
);
  logic [3:0] len_q, cnt_q;
  // the sequencer stalls while the acknowledge runs, so no boundary falls inside it
  assign instr_penult = !ack_busy && (cnt_q == len_q - 4'h2);
  assign instr_last = !ack_busy && (cnt_q == len_q - 4'h1);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
      len_q <= 4'h4;
      psw_stack_data <= 8'h00;
    end else begin
      // one stack level: the bench never nests deeper than one
      if (push_psw) begin
        psw_stack_data <= program_status_word;
      end
      if (instr_last) begin
        cnt_q <= 4'h0;
        // shorter than two clocks would lose the penult marker
        len_q <= (instr_len < 4'h2) ? 4'h2 : instr_len;
      end else if (!ack_busy) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// [sim/iac_accept_tb.sv]
// self-checking bench for the interrupt acceptance logic
`timescale 1ns/1ps
module iac_accept_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic ext_irq_in_a = 1'b0;
  logic ext_irq_in_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] periph_req = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] psw_wdata = 8'h00;
  logic [15:0] reg_addr = 16'h0000;
  logic irq_on_instr = 1'b0;
  logic irq_off_instr = 1'b0;
  logic return_from_irq_instr = 1'b0;
  logic psw_pop = 1'b0;
  logic nmi_req = 1'b0;
  logic psw_wr = 1'b0;
  logic pc_q = 1'b0;
  logic [3:0] instr_len = 4'h4;
  logic [7:0] reg_rdata, psw_stack_data, program_status_word;
  logic instr_penult, instr_last, ack_busy, push_psw, push_pc, vec_load, vec_nmi;
  logic [2:0] vec_src;
  logic [1:0] ma, mb;
  logic [3:0] e;
  logic [7:0] exp_rd[$];
  logic [3:0] exp_vec[$];
  int bad_count = 0;
  int total_checks = 0;
  int m;

  always #10 clock = ~clock;

  iac_accept DUT (.clock(clock), .nrst(nrst), .ext_irq_in_a(ext_irq_in_a),
    .ext_irq_in_b(ext_irq_in_b), .periph_req(periph_req), .nmi_req(nmi_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .psw_wr(psw_wr), .psw_wdata(psw_wdata),
    .irq_on_instr(irq_on_instr), .irq_off_instr(irq_off_instr),
    .return_from_irq_instr(return_from_irq_instr), .psw_pop(psw_pop),
    .psw_stack_data(psw_stack_data),
    .program_status_word(program_status_word), .instr_penult(instr_penult),
    .instr_last(instr_last), .ack_busy(ack_busy), .push_psw(push_psw), .push_pc(push_pc),
    .vec_load(vec_load), .vec_nmi(vec_nmi), .vec_src(vec_src));

  iac_core_model core (.clock(clock), .nrst(nrst), .instr_len(instr_len),
    .ack_busy(ack_busy), .push_psw(push_psw), .program_status_word(program_status_word),
    .instr_penult(instr_penult), .instr_last(instr_last), .psw_stack_data(psw_stack_data));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read and acknowledge results are judged here, in the order the driver noted them
  always @(posedge clock) begin
    if (rd_q) begin
      chk(reg_rdata, exp_rd.pop_front());
    end
    if (vec_load === 1'b1) begin
      if (exp_vec.size() == 0) begin
        bad_count++;
        $display("ERROR %0t: acknowledge with none expected", $time);
      end else begin
        e = exp_vec.pop_front();
        chk({4'h0, vec_nmi, vec_nmi ? 3'h0 : vec_src}, {4'h0, e});
        chk({7'h0, pc_q}, 8'h01);
      end
    end
    rd_q <= reg_rd;
    pc_q <= push_pc;
  end

  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock);
      instr_len <= 4'(2 + $urandom % 9);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    if (!w) exp_rd.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    step(1);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    step(1);
  endtask

  task automatic pulse(input logic [5:0] c, input logic [7:0] p);
    {psw_wr, nmi_req, psw_pop, return_from_irq_instr, irq_off_instr, irq_on_instr} <= c;
    periph_req <= p;
    step(1);
    {psw_wr, nmi_req, psw_pop, return_from_irq_instr, irq_off_instr, irq_on_instr} <= 6'h00;
    periph_req <= 8'h00;
    step(1);
  endtask

  task automatic drain();
    int k = 0;
    while (exp_vec.size() != 0 && k < 300) begin
      step(1);
      k++;
    end
    if (exp_vec.size() != 0) begin
      bad_count++;
      $display("ERROR %0t: acknowledge missing", $time);
      exp_vec.delete();
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    // waits on the clock alone so that only the test process drives stimulus
    repeat (20000) @(posedge clock);
    bad_count++;
    summarize();
  end

  initial begin
    void'($urandom(73325));
    step(16);
    nrst <= 1'b1;
    step(2);
    chk(program_status_word, iac_pkg::PSW_RESET);
    bus(1'b0, iac_pkg::ADDR_EDGE_MODE, 8'h00);
    bus(1'b0, iac_pkg::ADDR_MASK_FLAGS, 8'hff);
    bus(1'b0, iac_pkg::ADDR_REQ_FLAGS, 8'h00);
    bus(1'b0, 16'hffe8, 8'h00);
    bus(1'b1, iac_pkg::ADDR_EDGE_MODE, 8'hff);
    bus(1'b0, iac_pkg::ADDR_EDGE_MODE, 8'h3c);
    // every edge code on both inputs, masked throughout as software must
    for (m = 0; m < 4; m++) begin
      ma = 2'(m);
      mb = 2'(3 - m);
      bus(1'b1, iac_pkg::ADDR_EDGE_MODE, {2'h0, mb, ma, 2'h0});
      bus(1'b1, iac_pkg::ADDR_REQ_FLAGS, 8'h00);
      ext_irq_in_a <= 1'b1;
      ext_irq_in_b <= 1'b1;
      step(3);
      bus(1'b0, iac_pkg::ADDR_REQ_FLAGS, {6'h0, mb == 2'h1 || mb == 2'h3,
        ma == 2'h1 || ma == 2'h3});
      bus(1'b1, iac_pkg::ADDR_REQ_FLAGS, 8'h00);
      ext_irq_in_a <= 1'b0;
      ext_irq_in_b <= 1'b0;
      step(3);
      bus(1'b0, iac_pkg::ADDR_REQ_FLAGS, {6'h0, mb[1] == mb[0], ma[1] == ma[0]});
    end
    bus(1'b1, iac_pkg::ADDR_REQ_FLAGS, 8'h00);
    bus(1'b1, iac_pkg::ADDR_MASK_FLAGS, 8'h02);
    pulse(6'h01, 8'h00);
    chk({7'h0, program_status_word[7]}, 8'h01);
    exp_vec.push_back(4'h2);
    pulse(6'h00, 8'h0e);
    drain();
    chk({7'h0, program_status_word[7]}, 8'h00);
    chk({7'h0, psw_stack_data[7]}, 8'h01);
    step(40);
    exp_vec.push_back(4'h3);
    pulse(6'h04, 8'h00);
    drain();
    pulse(6'h04, 8'h00);
    chk({7'h0, program_status_word[7]}, 8'h01);
    step(40);
    exp_vec.push_back(4'h1);
    bus(1'b1, iac_pkg::ADDR_MASK_FLAGS, 8'h00);
    drain();
    pulse(6'h04, 8'h00);
    exp_vec.push_back(4'h8);
    pulse(6'h10, 8'h20);
    drain();
    pulse(6'h10, 8'h00);
    step(40);
    exp_vec.push_back(4'h8);
    pulse(6'h04, 8'h00);
    drain();
    exp_vec.push_back(4'h5);
    pulse(6'h04, 8'h00);
    drain();
    pulse(6'h04, 8'h00);
    pulse(6'h02, 8'h00);
    chk({7'h0, program_status_word[7]}, 8'h00);
    psw_wdata <= 8'($urandom);
    pulse(6'h20, 8'h00);
    chk(program_status_word, psw_wdata);
    pulse(6'h08, 8'h00);
    chk(program_status_word, psw_stack_data);
    step(10);
    summarize();
  end
endmodule
